// ### logic/dpbc_defs.svh
// Purpose: shared constants of the dual-port burst counter and mailbox logic
// Assumes: 17-bit port address, four byte lanes per port
// Notes: widths here are defaults; modules take them as parameters
`ifndef DPBC_DEFS_SVH
`define DPBC_DEFS_SVH

`define DPBC_ADDR_W 17
`define DPBC_LANES 4
`define DPBC_MBOX_RIGHT 17'h1ffff
`define DPBC_MBOX_LEFT 17'h1fffe
`define DPBC_CNT_RST 17'h00000
`define DPBC_MASK_RST 17'h1ffff
`define DPBC_STEP_ONE 17'h00001
`define DPBC_STEP_TWO 17'h00002
`define DPBC_PORTS 2

`endif

// ### logic/dpbc_pkg.sv
// Purpose: types of the dual-port burst counter and mailbox logic
// Assumes: decoded control is one operation per port per cycle
// Notes: decode order follows the counter/mask control table
package dpbc_pkg;

    typedef enum logic [3:0] {
        DPBC_CNT_CLR,
        DPBC_CNT_LOAD,
        DPBC_CNT_READ,
        DPBC_CNT_INC,
        DPBC_CNT_HOLD,
        DPBC_MSK_CLR,
        DPBC_MSK_LOAD,
        DPBC_MSK_READ,
        DPBC_MSK_UNDEF
    } dpbc_op_t;

    function automatic dpbc_op_t dpbc_decode(input logic sel, input logic clr_n,
                                             input logic strobe_n, input logic cen_n);
        dpbc_op_t op;
        op = DPBC_CNT_HOLD;
        if (sel) begin
            if (!clr_n) op = DPBC_CNT_CLR;
            else if (!strobe_n && !cen_n) op = DPBC_CNT_LOAD;
            else if (!strobe_n) op = DPBC_CNT_READ;
            else if (!cen_n) op = DPBC_CNT_INC;
            else op = DPBC_CNT_HOLD;
        end else begin
            if (!clr_n) op = DPBC_MSK_CLR;
            else if (!strobe_n && !cen_n) op = DPBC_MSK_LOAD;
            else if (!strobe_n) op = DPBC_MSK_READ;
            else op = DPBC_MSK_UNDEF;
        end
        return op;
    endfunction

endpackage

// ### logic/dpbc_counter.sv
// Purpose: burst counter with mask and mirror registers for one port
// Assumes: op is already decoded and sampled on the port clock
// Notes: cnt_d is the address used by this cycle's access
`timescale 1ns/1ps
`include "dpbc_defs.svh"
module dpbc_counter #(
    parameter int AW = `DPBC_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire dpbc_pkg::dpbc_op_t op,
    input wire logic [AW-1:0] addr_in,
    output logic [AW-1:0] cnt_q,
    output logic [AW-1:0] mask_q,
    output logic [AW-1:0] mirror_q,
    output logic [AW-1:0] cnt_d,
    output logic wrap_irq_n_q
);
    localparam logic [AW-1:0] ALL_ONES = {AW{1'b1}};
    localparam logic [AW-1:0] CNT_RST = AW'(`DPBC_CNT_RST);
    localparam logic [AW-1:0] MASK_RST = AW'(`DPBC_MASK_RST);
    localparam logic [AW-1:0] STEP_ONE = AW'(`DPBC_STEP_ONE);
    localparam logic [AW-1:0] STEP_TWO = AW'(`DPBC_STEP_TWO);

    logic [AW-1:0] mask_d;
    logic [AW-1:0] mirror_d;
    logic wrap_irq_n_d;
    logic [AW-1:0] step;
    logic [AW-1:0] sum;
    logic at_top;

    always_comb begin
        cnt_d = cnt_q;
        mask_d = mask_q;
        mirror_d = mirror_q;
        wrap_irq_n_d = wrap_irq_n_q;
        // a cleared mask bit 0 freezes the lsb, so count in twos
        step = mask_q[0] ? STEP_ONE : STEP_TWO; // R18
        // carry into masked upper bits is dropped by the mask below
        sum = (cnt_q & mask_q) + step;
        at_top = ((cnt_q | ~mask_q) == ALL_ONES);
        case (op)
            dpbc_pkg::DPBC_CNT_CLR: begin
                cnt_d = cnt_q & ~mask_q; // R17
                mirror_d = mirror_q & ~mask_q; // R17
                wrap_irq_n_d = 1'b1; // R24
            end
            dpbc_pkg::DPBC_CNT_LOAD: begin
                cnt_d = addr_in; // R13
                mirror_d = addr_in; // R13
                wrap_irq_n_d = 1'b1; // R24
            end
            dpbc_pkg::DPBC_CNT_INC: begin
                if (at_top) begin
                    cnt_d = mirror_q; // R19
                end else begin
                    cnt_d = (cnt_q & ~mask_q) | (sum & mask_q); // R18
                end
                // flag follows the value the increment produced
                wrap_irq_n_d = !((cnt_d | ~mask_q) == ALL_ONES); // R20 R21
            end
            dpbc_pkg::DPBC_MSK_CLR: begin
                mask_d = MASK_RST; // R16
                wrap_irq_n_d = 1'b1; // R24
            end
            dpbc_pkg::DPBC_MSK_LOAD: begin
                mask_d = addr_in;
                wrap_irq_n_d = 1'b1; // R24
            end
            // readback, hold and the undefined mask case keep all registers
            default: begin
                cnt_d = cnt_q; // R23
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= CNT_RST; // R1
            mirror_q <= CNT_RST; // R1
            mask_q <= MASK_RST; // R1
            wrap_irq_n_q <= 1'b1; // R2
        end else begin
            cnt_q <= cnt_d;
            mirror_q <= mirror_d;
            mask_q <= mask_d;
            wrap_irq_n_q <= wrap_irq_n_d;
        end
    end
endmodule

// ### logic/dpbc_mailbox.sv
// Purpose: one mailbox interrupt flag, active low
// Assumes: set and clear are single-cycle strobes on the common clock
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps
module dpbc_mailbox (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic irq_n_q
);
    logic irq_n_d;

    always_comb begin
        irq_n_d = irq_n_q;
        if (set) begin
            irq_n_d = 1'b0; // R5 R26
        end else if (clr) begin
            irq_n_d = 1'b1; // R6 R25
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_n_q <= 1'b1; // R2
        end else begin
            irq_n_q <= irq_n_d; // R7
        end
    end
endmodule

// ### logic/dpbc_top.sv
// Purpose: per-port burst counter, counter wrap flag and mailbox flags of a dual-port RAM
// Assumes: both ports run on clk; rst is the master reset, active high, asynchronous
// Notes: the memory array itself sits outside; this block drives its address and strobes
//
// Behaviour
// R1: master reset zeroes counters, masks to ones
// R2: master reset drives all interrupts high
// R3: system applies one master reset after power-up
// R4: top word right mailbox, next left
// R5: other port write with lane sets flag
// R6: owner read with lane clears flag
// R7: set and clear act on that edge
// R8: other read, own write leave flags
// R9: counter select decodes five counter operations
// R10: mask select decodes three mask operations
// R11: counter, mask and mirror per port
// R12: controls sampled on clock, ignore enables
// R13: load writes counter and mirror together
// R14: master loads only contiguous mask values
// R15: readback on address lines, data three-stated
// R16: mask reset sets all mask bits
// R17: counter reset clears unmasked bits only
// R18: increment by one or two, unmasked
// R19: increment at top reloads from mirror
// R20: wrap flag low when increment reaches top
// R21: wrap flag high on other increment
// R22: wrap flag may feed counter clear
// R23: hold keeps all three registers
// R24: loads and resets also raise flag
// R25: mailbox flag active low, owner clears
// R26: simultaneous set and clear, set wins
`timescale 1ns/1ps
`include "dpbc_defs.svh"
module dpbc_top #(
    parameter int AW = `DPBC_ADDR_W,
    parameter int LANES = `DPBC_LANES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic counter_or_mask_sel_l,
    input wire logic counter_clear_n_l,
    input wire logic addr_strobe_n_l,
    input wire logic count_enable_n_l,
    input wire logic chip_sel_lo_n_l,
    input wire logic chip_sel_hi_l,
    input wire logic write_n_l,
    input wire logic [LANES-1:0] byte_lane_sel_n_l,
    input wire logic [AW-1:0] addr_in_l,
    output logic [AW-1:0] addr_out_l,
    output logic addr_out_en_l,
    output logic dq_hiz_l,
    output logic [AW-1:0] mem_addr_l,
    output logic mem_wr_l,
    output logic mem_rd_l,
    output logic [LANES-1:0] mem_lane_n_l,
    output logic wrap_irq_n_l,
    output logic mbox_irq_n_l,
    input wire logic counter_or_mask_sel_r,
    input wire logic counter_clear_n_r,
    input wire logic addr_strobe_n_r,
    input wire logic count_enable_n_r,
    input wire logic chip_sel_lo_n_r,
    input wire logic chip_sel_hi_r,
    input wire logic write_n_r,
    input wire logic [LANES-1:0] byte_lane_sel_n_r,
    input wire logic [AW-1:0] addr_in_r,
    output logic [AW-1:0] addr_out_r,
    output logic addr_out_en_r,
    output logic dq_hiz_r,
    output logic [AW-1:0] mem_addr_r,
    output logic mem_wr_r,
    output logic mem_rd_r,
    output logic [LANES-1:0] mem_lane_n_r,
    output logic wrap_irq_n_r,
    output logic mbox_irq_n_r
);
    localparam int NP = `DPBC_PORTS;
    localparam logic [AW-1:0] MBOX_RIGHT = AW'(`DPBC_MBOX_RIGHT);
    localparam logic [AW-1:0] MBOX_LEFT = AW'(`DPBC_MBOX_LEFT);

    // index 0 is the left port, index 1 the right port
    logic sel [NP];
    logic clr_n [NP];
    logic strobe_n [NP];
    logic cen_n [NP];
    logic enabled [NP];
    logic wr_n [NP];
    logic [LANES-1:0] lane_n [NP];
    logic [AW-1:0] addr_in [NP];
    logic [AW-1:0] mbox_addr [NP];

    dpbc_pkg::dpbc_op_t op [NP];
    logic [AW-1:0] cnt_q [NP];
    logic [AW-1:0] mask_q [NP];
    logic [AW-1:0] mirror_q [NP];
    logic [AW-1:0] cnt_d [NP];
    logic wrap_q [NP];
    logic mbox_q [NP];

    logic access [NP];
    logic is_write [NP];
    logic is_read [NP];
    logic hits_mbox [NP][NP];
    logic mbox_set [NP];
    logic mbox_clr [NP];

    logic [AW-1:0] addr_out_q [NP];
    logic [AW-1:0] addr_out_d [NP];
    logic addr_out_en_q [NP];
    logic addr_out_en_d [NP];
    logic dq_hiz_q [NP];
    logic dq_hiz_d [NP];
    logic mem_wr_q [NP];
    logic mem_wr_d [NP];
    logic mem_rd_q [NP];
    logic mem_rd_d [NP];
    logic [LANES-1:0] mem_lane_n_q [NP];
    logic [LANES-1:0] mem_lane_n_d [NP];

    assign sel[0] = counter_or_mask_sel_l;
    assign sel[1] = counter_or_mask_sel_r;
    assign clr_n[0] = counter_clear_n_l;
    assign clr_n[1] = counter_clear_n_r;
    assign strobe_n[0] = addr_strobe_n_l;
    assign strobe_n[1] = addr_strobe_n_r;
    assign cen_n[0] = count_enable_n_l;
    assign cen_n[1] = count_enable_n_r;
    assign enabled[0] = !chip_sel_lo_n_l && chip_sel_hi_l;
    assign enabled[1] = !chip_sel_lo_n_r && chip_sel_hi_r;
    assign wr_n[0] = write_n_l;
    assign wr_n[1] = write_n_r;
    assign lane_n[0] = byte_lane_sel_n_l;
    assign lane_n[1] = byte_lane_sel_n_r;
    assign addr_in[0] = addr_in_l;
    assign addr_in[1] = addr_in_r;
    assign mbox_addr[0] = MBOX_LEFT; // R4
    assign mbox_addr[1] = MBOX_RIGHT; // R4

    genvar p;
    genvar o;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            // counter and mask decode ignores the chip enables entirely
            assign op[p] = dpbc_pkg::dpbc_decode(sel[p], clr_n[p], strobe_n[p],
                                                 cen_n[p]); // R9 R10 R12

            dpbc_counter #(
                .AW(AW)
            ) u_counter (
                .clk(clk),
                .rst(rst),
                .op(op[p]),
                .addr_in(addr_in[p]),
                .cnt_q(cnt_q[p]),
                .mask_q(mask_q[p]),
                .mirror_q(mirror_q[p]),
                .cnt_d(cnt_d[p]),
                .wrap_irq_n_q(wrap_q[p])
            ); // R11

            // a readback cycle drives the address lines, so it is no array access
            assign access[p] = enabled[p] && (lane_n[p] != '1) &&
                               (op[p] != dpbc_pkg::DPBC_CNT_READ) &&
                               (op[p] != dpbc_pkg::DPBC_MSK_READ);
            assign is_write[p] = access[p] && !wr_n[p];
            assign is_read[p] = access[p] && wr_n[p];

            for (o = 0; o < NP; o++) begin : g_hit
                assign hits_mbox[p][o] = (cnt_d[p] == mbox_addr[o]);
            end

            // only the far port sets, only the owner clears
            assign mbox_set[p] = is_write[NP-1-p] && hits_mbox[NP-1-p][p]; // R5 R8
            assign mbox_clr[p] = is_read[p] && hits_mbox[p][p]; // R6 R8

            dpbc_mailbox u_mailbox (
                .clk(clk),
                .rst(rst),
                .set(mbox_set[p]),
                .clr(mbox_clr[p]),
                .irq_n_q(mbox_q[p])
            ); // R7 R26

            always_comb begin
                addr_out_d[p] = '0;
                addr_out_en_d[p] = 1'b0;
                dq_hiz_d[p] = 1'b0;
                if (op[p] == dpbc_pkg::DPBC_CNT_READ) begin
                    addr_out_d[p] = cnt_q[p]; // R15
                    addr_out_en_d[p] = 1'b1; // R15
                    dq_hiz_d[p] = enabled[p]; // R15
                end else if (op[p] == dpbc_pkg::DPBC_MSK_READ) begin
                    addr_out_d[p] = mask_q[p]; // R15
                    addr_out_en_d[p] = 1'b1; // R15
                    dq_hiz_d[p] = enabled[p]; // R15
                end
                mem_wr_d[p] = is_write[p];
                mem_rd_d[p] = is_read[p];
                mem_lane_n_d[p] = access[p] ? lane_n[p] : '1;
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    addr_out_q[p] <= '0;
                    addr_out_en_q[p] <= 1'b0;
                    dq_hiz_q[p] <= 1'b0;
                    mem_wr_q[p] <= 1'b0;
                    mem_rd_q[p] <= 1'b0;
                    mem_lane_n_q[p] <= '1;
                end else begin
                    addr_out_q[p] <= addr_out_d[p];
                    addr_out_en_q[p] <= addr_out_en_d[p];
                    dq_hiz_q[p] <= dq_hiz_d[p];
                    mem_wr_q[p] <= mem_wr_d[p];
                    mem_rd_q[p] <= mem_rd_d[p];
                    mem_lane_n_q[p] <= mem_lane_n_d[p];
                end
            end
        end
    endgenerate

    // all outputs below are flop outputs passed straight to the pins
    assign addr_out_l = addr_out_q[0];
    assign addr_out_en_l = addr_out_en_q[0];
    assign dq_hiz_l = dq_hiz_q[0];
    assign mem_addr_l = cnt_q[0];
    assign mem_wr_l = mem_wr_q[0];
    assign mem_rd_l = mem_rd_q[0];
    assign mem_lane_n_l = mem_lane_n_q[0];
    assign wrap_irq_n_l = wrap_q[0];
    assign mbox_irq_n_l = mbox_q[0];
    assign addr_out_r = addr_out_q[1];
    assign addr_out_en_r = addr_out_en_q[1];
    assign dq_hiz_r = dq_hiz_q[1];
    assign mem_addr_r = cnt_q[1];
    assign mem_wr_r = mem_wr_q[1];
    assign mem_rd_r = mem_rd_q[1];
    assign mem_lane_n_r = mem_lane_n_q[1];
    assign wrap_irq_n_r = wrap_q[1];
    assign mbox_irq_n_r = mbox_q[1];
endmodule

// ### testbench/dpbc_top_asserts.sv
// Purpose: port-level assertions for dpbc_top
// Assumes: one clock for both ports, rst active high
// Notes: counter checks watch the left port; mailbox checks watch the right port's flag
`timescale 1ns/1ps
module dpbc_top_chk #(
    parameter int AW = 17,
    parameter int LANES = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic counter_or_mask_sel_l,
    input wire logic counter_clear_n_l,
    input wire logic addr_strobe_n_l,
    input wire logic count_enable_n_l,
    input wire logic chip_sel_lo_n_l,
    input wire logic chip_sel_hi_l,
    input wire logic write_n_l,
    input wire logic [LANES-1:0] byte_lane_sel_n_l,
    input wire logic [AW-1:0] addr_in_l,
    input wire logic [AW-1:0] addr_out_l,
    input wire logic addr_out_en_l,
    input wire logic dq_hiz_l,
    input wire logic [AW-1:0] mem_addr_l,
    input wire logic wrap_irq_n_l,
    input wire logic mbox_irq_n_l,
    input wire logic counter_clear_n_r,
    input wire logic addr_strobe_n_r,
    input wire logic count_enable_n_r,
    input wire logic chip_sel_lo_n_r,
    input wire logic chip_sel_hi_r,
    input wire logic write_n_r,
    input wire logic [LANES-1:0] byte_lane_sel_n_r,
    input wire logic [AW-1:0] mem_addr_r,
    input wire logic mbox_irq_n_r
);
    logic en_l, en_r, rb_l, rb_r, acc_l, acc_r;
    assign en_l = !chip_sel_lo_n_l && chip_sel_hi_l;
    assign en_r = !chip_sel_lo_n_r && chip_sel_hi_r;
    assign rb_l = counter_clear_n_l && !addr_strobe_n_l && count_enable_n_l;
    assign rb_r = counter_clear_n_r && !addr_strobe_n_r && count_enable_n_r;
    // readback is not an array access, so it never touches a mailbox
    assign acc_l = en_l && !(&byte_lane_sel_n_l) && !rb_l;
    assign acc_r = en_r && !(&byte_lane_sel_n_r) && !rb_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_reset_flags: assert property (
        $fell(rst) |-> wrap_irq_n_l && mbox_irq_n_l && mbox_irq_n_r && mem_addr_l == '0)
        else $error("flags or counter not idle after reset");
    chk_load_copy: assert property (
        counter_or_mask_sel_l && counter_clear_n_l && !addr_strobe_n_l && !count_enable_n_l
        |=> mem_addr_l == $past(addr_in_l) && wrap_irq_n_l)
        else $error("counter load wrong");
    chk_wrap_raise: assert property (
        !counter_clear_n_l || (!counter_or_mask_sel_l && !addr_strobe_n_l && !count_enable_n_l)
        |=> wrap_irq_n_l)
        else $error("wrap flag not raised by reset or load");
    chk_hold_keep: assert property (
        counter_clear_n_l && addr_strobe_n_l && (count_enable_n_l || !counter_or_mask_sel_l)
        |=> $stable(mem_addr_l) && $stable(wrap_irq_n_l))
        else $error("counter moved during hold");
    chk_readback_val: assert property (
        counter_or_mask_sel_l && rb_l |=> addr_out_en_l && addr_out_l == $past(mem_addr_l))
        else $error("counter readback wrong");
    chk_readback_hiz: assert property (
        rb_l |=> dq_hiz_l == $past(en_l))
        else $error("data three-state wrong on readback");
    chk_no_readback: assert property (
        !rb_l |=> !addr_out_en_l && !dq_hiz_l)
        else $error("readback outputs without readback");
    chk_mbox_set: assert property (
        (acc_l && !write_n_l) ##1 (mem_addr_l == 17'h1ffff) |-> !mbox_irq_n_r)
        else $error("mailbox flag not set");
    chk_far_read: assert property (
        (acc_l && write_n_l && !en_r) ##1 (mem_addr_l == 17'h1ffff) |-> $stable(mbox_irq_n_r))
        else $error("far read changed mailbox flag");
    chk_own_clear: assert property (
        (acc_r && write_n_r && !en_l) ##1 (mem_addr_r == 17'h1ffff) |-> mbox_irq_n_r)
        else $error("owner read did not clear flag");
    cover property ($fell(wrap_irq_n_l));
    cover property ($fell(mbox_irq_n_r));
    cover property (dq_hiz_l);
endmodule

bind dpbc_top dpbc_top_chk #(.AW(AW), .LANES(LANES)) i_dpbc_top_chk (.*);

// ### testbench/dpbc_host.sv
// Purpose: host model driving the control pins of one port
// Assumes: pins change by non-blocking assignment at the rising edge
// Notes: every operation is followed by one deselected hold cycle
`timescale 1ns/1ps
module dpbc_host (
    input wire logic clk,
    output logic counter_or_mask_sel,
    output logic counter_clear_n,
    output logic addr_strobe_n,
    output logic count_enable_n,
    output logic chip_sel_lo_n,
    output logic chip_sel_hi,
    output logic write_n,
    output logic [3:0] byte_lane_sel_n,
    output logic [16:0] addr_in
);
    initial begin
        {counter_or_mask_sel, counter_clear_n, addr_strobe_n, count_enable_n} = 4'hf;
        {chip_sel_lo_n, chip_sel_hi, write_n, byte_lane_sel_n} = 7'h5f;
        addr_in = 17'h0;
    end
    task automatic drv(input logic [3:0] ctl, input logic [16:0] a = 17'h0,
            input logic en = 1'h0, input logic wr_n = 1'h1, input logic [3:0] ln = 4'hf);
        @(posedge clk);
        {counter_or_mask_sel, counter_clear_n, addr_strobe_n, count_enable_n} <= ctl;
        {chip_sel_lo_n, chip_sel_hi, write_n, byte_lane_sel_n} <= {!en, en, wr_n, ln};
        addr_in <= a;
        @(posedge clk);
        {counter_or_mask_sel, counter_clear_n, addr_strobe_n, count_enable_n} <= 4'hf;
        {chip_sel_lo_n, chip_sel_hi, write_n, byte_lane_sel_n} <= 7'h5f;
        // idle address lines carry junk, so a stale value cannot pass a check
        addr_in <= ~a;
        #1;
    endtask
endmodule

// ### testbench/dpbc_top_tb.sv
// Purpose: self-checking bench for dpbc_top
// Assumes: each port driven by its own host model on the shared clock
// Notes: back-to-back op timing is left to the checker
`timescale 1ns/1ps
module dpbc_top_tb;
    localparam logic [3:0] LD = 4'hc, RB = 4'hd, INC = 4'he, HLD = 4'hf, CCL = 4'hb;
    localparam logic [3:0] MCL = 4'h3, MLD = 4'h4, MRB = 4'h5, MUN = 4'h6;
    logic clk = 1'h0;
    logic rst;
    logic counter_or_mask_sel_l, counter_clear_n_l, addr_strobe_n_l, count_enable_n_l;
    logic chip_sel_lo_n_l, chip_sel_hi_l, write_n_l, addr_out_en_l, dq_hiz_l;
    logic mem_wr_l, mem_rd_l, wrap_irq_n_l, mbox_irq_n_l;
    logic [3:0] byte_lane_sel_n_l, mem_lane_n_l;
    logic [16:0] addr_in_l, addr_out_l, mem_addr_l;
    logic counter_or_mask_sel_r, counter_clear_n_r, addr_strobe_n_r, count_enable_n_r;
    logic chip_sel_lo_n_r, chip_sel_hi_r, write_n_r, addr_out_en_r, dq_hiz_r;
    logic mem_wr_r, mem_rd_r, wrap_irq_n_r, mbox_irq_n_r;
    logic [3:0] byte_lane_sel_n_r, mem_lane_n_r;
    logic [16:0] addr_in_r, addr_out_r, mem_addr_r;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    dpbc_top i_dpbc_top (.*);
    dpbc_host i_host_l (.clk(clk), .counter_or_mask_sel(counter_or_mask_sel_l),
        .counter_clear_n(counter_clear_n_l), .addr_strobe_n(addr_strobe_n_l),
        .count_enable_n(count_enable_n_l), .chip_sel_lo_n(chip_sel_lo_n_l),
        .chip_sel_hi(chip_sel_hi_l), .write_n(write_n_l),
        .byte_lane_sel_n(byte_lane_sel_n_l), .addr_in(addr_in_l));
    dpbc_host i_host_r (.clk(clk), .counter_or_mask_sel(counter_or_mask_sel_r),
        .counter_clear_n(counter_clear_n_r), .addr_strobe_n(addr_strobe_n_r),
        .count_enable_n(count_enable_n_r), .chip_sel_lo_n(chip_sel_lo_n_r),
        .chip_sel_hi(chip_sel_hi_r), .write_n(write_n_r),
        .byte_lane_sel_n(byte_lane_sel_n_r), .addr_in(addr_in_r));
    task automatic test_done();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp({16'h0, got}, {16'h0, exp});
    endtask
    task automatic t_reset();
        cmp(mem_addr_l, 17'h0);
        cmp1(wrap_irq_n_l & wrap_irq_n_r & mbox_irq_n_l & mbox_irq_n_r, 1'h1);
        i_host_l.drv(MRB);
        cmp(addr_out_l, 17'h1ffff);
        cmp1(addr_out_en_l, 1'h1);
    endtask
    task automatic t_burst(input logic [16:0] m, input logic [16:0] s);
        logic [16:0] e;
        logic [16:0] st;
        st = m[0] ? 17'h1 : 17'h2;
        i_host_l.drv(MLD, m);
        i_host_l.drv(MRB, 17'h0, 1'h1);
        cmp(addr_out_l, m);
        cmp1(dq_hiz_l, 1'h1);
        i_host_l.drv(LD, s);
        e = s;
        cmp(mem_addr_l, e);
        for (int i = 0; i < 70; i++) begin
            i_host_l.drv(INC);
            e = ((e & m) == m) ? s : ((e & ~m) | ((e + st) & m));
            cmp(mem_addr_l, e);
            cmp1(wrap_irq_n_l, (e & m) != m);
        end
        i_host_l.drv(HLD, 17'h0, 1'h1);
        i_host_l.drv(MUN, 17'h0, 1'h1);
        i_host_l.drv(RB);
        cmp(addr_out_l, e);
        cmp1(dq_hiz_l, 1'h0);
    endtask
    task automatic t_clr();
        i_host_l.drv(MLD, 17'h3);
        i_host_l.drv(LD, 17'h1233e);
        i_host_l.drv(INC);
        cmp1(wrap_irq_n_l, 1'h0);
        i_host_l.drv(CCL);
        cmp(mem_addr_l, 17'h1233c);
        cmp1(wrap_irq_n_l, 1'h1);
        repeat (4) i_host_l.drv(INC);
        cmp(mem_addr_l, 17'h1233c);
        repeat (3) i_host_l.drv(INC);
        i_host_l.drv(MCL);
        cmp1(wrap_irq_n_l, 1'h1);
        i_host_l.drv(MRB);
        cmp(addr_out_l, 17'h1ffff);
        i_host_l.drv(CCL);
        cmp(mem_addr_l, 17'h0);
    endtask
    task automatic t_mbox();
        i_host_l.drv(LD, 17'h1ffff, 1'h1, 1'h0, 4'hf);
        cmp1(mbox_irq_n_r, 1'h1);
        i_host_l.drv(LD, 17'h1ffff, 1'h1, 1'h0, 4'he);
        cmp1(mbox_irq_n_r, 1'h0);
        cmp1(mem_wr_l, 1'h1);
        cmp({13'h0, mem_lane_n_l}, 17'h0000e);
        i_host_l.drv(LD, 17'h1ffff, 1'h1, 1'h1, 4'h0);
        cmp1(mbox_irq_n_r, 1'h0);
        i_host_r.drv(LD, 17'h1ffff, 1'h1, 1'h1, 4'hf);
        cmp1(mbox_irq_n_r, 1'h0);
        i_host_r.drv(LD, 17'h1ffff, 1'h1, 1'h1, 4'h7);
        cmp1(mbox_irq_n_r, 1'h1);
        cmp1(mem_rd_r, 1'h1);
        cmp({13'h0, mem_lane_n_r}, 17'h00007);
        i_host_r.drv(LD, 17'h1ffff, 1'h1, 1'h0, 4'h0);
        cmp1(mbox_irq_n_r, 1'h1);
        fork
            i_host_l.drv(LD, 17'h1ffff, 1'h1, 1'h0, 4'hd);
            i_host_r.drv(LD, 17'h1ffff, 1'h1, 1'h1, 4'hd);
        join
        cmp1(mbox_irq_n_r, 1'h0);
        i_host_r.drv(LD, 17'h1fffe, 1'h1, 1'h0, 4'he);
        cmp1(mbox_irq_n_l, 1'h0);
        i_host_l.drv(LD, 17'h1fffe, 1'h0, 1'h1, 4'he);
        cmp1(mbox_irq_n_l, 1'h0);
        i_host_l.drv(LD, 17'h1fffe, 1'h1, 1'h1, 4'he);
        cmp1(mbox_irq_n_l, 1'h1);
        i_host_r.drv(RB);
        cmp(addr_out_r, 17'h1fffe);
        cmp1(addr_out_en_r & wrap_irq_n_r, 1'h1);
    endtask
    // ceiling is several times the expected run, about 360 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        rst = 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        t_reset();
        t_burst(17'h0003f, 17'h10008);
        t_burst(17'h0003e, 17'h10008);
        t_clr();
        t_mbox();
        test_done();
    end
endmodule
